/* common/stc_pkg.sv */
// Constants, encodings and register map of the stream-to-context attribute block
package stc_pkg;

	// Register byte offsets
	localparam logic [11:0] OFF_CFG_BASE = 12'h000;
	localparam logic [11:0] OFF_CFG_LAST = 12'h3fc;
	localparam logic [11:0] OFF_NS_COUNT = 12'h400;
	localparam logic [11:0] OFF_FAULT_COUNT = 12'h404;

	// Field positions of stream_to_context_config
	localparam int IMPDEF_LSB = 30;
	localparam int TRANS_LSB = 28;
	localparam int FETCH_LSB = 26;
	localparam int FB_BIT = 26;
	localparam int PRIV_LSB = 24;
	localparam int BSU_LSB = 24;
	localparam int WALLOC_LSB = 22;
	localparam int RALLOC_LSB = 20;
	localparam int SEC_LSB = 18;
	localparam int TYPE_LSB = 16;
	localparam int MEMORY_ATTRIBUTE_VALUE_LSB = 12;
	localparam int MTSEL_BIT = 11;
	localparam int SHARE_LSB = 8;
	localparam int CB_LSB = 0;
	localparam int NSCOUNT_LSB = 8;

	// Bits that hold storage, per format
	localparam logic [31:0] MASK_XLATE = 32'hcff3fb00;
	localparam logic [31:0] MASK_BYPASS = 32'h04f3fb00;
	localparam logic [31:0] MASK_FAULT = 32'hf0030000;
	localparam logic [31:0] MASK_RSVD = 32'h00030000;
	localparam logic [31:0] MASK_TRANS = 32'h30000000;
	localparam logic [31:0] MASK_SEC = 32'h000c0000;
	localparam logic [31:0] MASK_BSU = 32'h03000000;

	// Reset values
	localparam logic [15:0] FAULT_COUNT_RST = 16'h0000;

	typedef enum logic [1:0] {
		CFG_XLATE = 2'b00,
		CFG_BYPASS = 2'b01,
		CFG_FAULT = 2'b10,
		CFG_RSVD = 2'b11
	} cfg_type_t;

	typedef enum logic [1:0] {
		PATH_XLATE = 2'b00,
		PATH_BYPASS = 2'b01,
		PATH_FAULT = 2'b10,
		PATH_NONE = 2'b11
	} path_t;

	// Two-bit override fields other than shareability share one encoding
	localparam logic [1:0] OVR_KEEP = 2'b00;
	localparam logic [1:0] OVR_FORCE_A = 2'b10;
	localparam logic [1:0] OVR_FORCE_B = 2'b11;

	// Shareability field codes and attribute encoding on the transaction ports
	localparam logic [1:0] SHAREABILITY_OVERRIDE_OUTER = 2'b01;
	localparam logic [1:0] SHAREABILITY_OVERRIDE_INNER = 2'b10;
	localparam logic [1:0] SHAREABILITY_OVERRIDE_NON = 2'b11;
	localparam logic [1:0] SH_NON = 2'b00;
	localparam logic [1:0] SH_INNER = 2'b01;
	localparam logic [1:0] SH_OUTER = 2'b10;

endpackage

/* tb/stc_chk.sv */
// Concurrent checks on the ports of the stream-to-context block
module stc_chk
	import stc_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic TXN_VALID,
	input wire logic TXN_MATCH,
	input wire logic [1:0] TXN_BAR_DOM,
	input wire logic OUT_VALID,
	input wire logic [1:0] OUT_PATH,
	input wire logic OUT_BROADCAST,
	input wire logic OUT_BARRIER,
	input wire logic [1:0] OUT_BAR_DOM,
	input wire logic OUT_CTX_FAULT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_access;
		PSEL && PENABLE;
	endsequence
	////////////////////////
	chk_one_wait: assert property (s_setup ##1 s_access |-> !PREADY ##1 PREADY)
		else $error("apb wait state wrong");
	chk_err_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
		else $error("slave error outside ready");
	chk_txn_lat: assert property (TXN_VALID |-> ##2 OUT_VALID)
		else $error("result missing two cycles on");
	chk_no_spur: assert property (!TXN_VALID |-> ##2 !OUT_VALID)
		else $error("result without transaction");
	chk_unmatch: assert property (TXN_VALID && !TXN_MATCH |->
		##2 OUT_PATH == PATH_NONE && !OUT_CTX_FAULT)
		else $error("unmatched transaction steered");
	chk_fault_flag: assert property (OUT_CTX_FAULT |-> OUT_VALID && OUT_PATH == PATH_FAULT)
		else $error("fault flag on wrong path");
	chk_fault_stop: assert property (OUT_VALID && OUT_PATH == PATH_FAULT |->
		OUT_CTX_FAULT && !OUT_BARRIER && !OUT_BROADCAST)
		else $error("faulted transaction forwarded");
	chk_bcast_path: assert property (OUT_BROADCAST |-> OUT_VALID && OUT_PATH == PATH_BYPASS)
		else $error("broadcast outside bypass");
	chk_bar_min: assert property (OUT_VALID && OUT_PATH == PATH_BYPASS && OUT_BARRIER |->
		OUT_BAR_DOM >= $past(TXN_BAR_DOM, 2))
		else $error("barrier domain lowered");
endmodule

bind stream_context_attr stc_chk stc_chk_inst (.*);

/* tb/stc_client.sv */
// Client bus master model issuing transactions toward the block
module stc_client (
	input wire logic CLK,
	output logic TXN_VALID,
	output logic TXN_MATCH,
	output logic [7:0] TXN_GROUP,
	output logic TXN_TRANSIENT,
	output logic TXN_INSTR,
	output logic TXN_PRIV,
	output logic TXN_WALLOC,
	output logic TXN_RALLOC,
	output logic TXN_NS,
	output logic [3:0] TXN_MEMORY_ATTRIBUTE_VALUE,
	output logic [1:0] TXN_SHARE,
	output logic TXN_MAINT,
	output logic TXN_BARRIER,
	output logic [1:0] TXN_BAR_DOM
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [9:0] hdr = 10'h000;
	logic [15:0] attr = 16'h5a5a;
	assign {TXN_VALID, TXN_MATCH, TXN_GROUP} = hdr;
	assign {TXN_TRANSIENT, TXN_INSTR, TXN_PRIV, TXN_WALLOC, TXN_RALLOC, TXN_NS,
		TXN_MEMORY_ATTRIBUTE_VALUE, TXN_SHARE, TXN_MAINT, TXN_BARRIER, TXN_BAR_DOM} = attr;
	////////////////////////
	task automatic send(input logic m, input logic [7:0] g, input logic [15:0] a);
		@(posedge CLK);
		hdr <= {1'b1, m, g};
		attr <= a;
	endtask
	// Idle fields show inverted junk so stale values never pass for live ones
	task automatic idle();
		@(posedge CLK);
		hdr <= {1'b0, ~hdr[8:0]};
		attr <= ~attr;
	endtask
endmodule

/* tb/stream_context_attr_bench.sv */
// Bench: registers over APB and transaction attribute overrides
module stream_context_attr_bench import stc_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0, PRDATA, rd;
	logic [2:0] PPROT = 3'h0;
	logic PREADY, PSLVERR, er, TXN_VALID, TXN_MATCH, TXN_TRANSIENT, TXN_INSTR, TXN_PRIV;
	logic TXN_WALLOC, TXN_RALLOC, TXN_NS, TXN_MAINT, TXN_BARRIER, OUT_VALID, OUT_TRANSIENT;
	logic OUT_INSTR, OUT_PRIV, OUT_WALLOC, OUT_RALLOC, OUT_NS, OUT_BROADCAST, OUT_BARRIER;
	logic OUT_CTX_FAULT;
	logic [7:0] TXN_GROUP;
	logic [3:0] TXN_MEMORY_ATTRIBUTE_VALUE, OUT_MEMORY_ATTRIBUTE_VALUE, OUT_CB_INDEX;
	logic [1:0] TXN_SHARE, TXN_BAR_DOM, OUT_PATH, OUT_SHARE, OUT_BAR_DOM;
	int failures = 0, n_tests = 0, cycles = 0;
	stream_context_attr stream_context_attr_inst (.*);
	stc_client stc_client_inst (.*);
	always #2.5 CLK = ~CLK;
	////////////////////////
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ns);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		PPROT <= {1'b0, ns, 1'b0};
		@(posedge CLK);
		PENABLE <= 1'b1;
		// Ready, data and error are taken at the completing rising edge; only the timeout ends a hang
		do begin
			@(posedge CLK);
		end while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
		apb(1'b1, a, d, 1'b0);
		apb(1'b0, a, 32'h0, 1'b0);
		chk("config", exp, rd);
		chk("slverr", 32'h0, {31'h0, er});
	endtask
	// Index only means something on the translate path, so it is masked elsewhere
	task automatic txn(input logic m, input logic [7:0] g, input logic [15:0] a,
		input logic [31:0] exp);
		stc_client_inst.send(m, g, a);
		stc_client_inst.idle();
		@(posedge CLK);
		@(negedge CLK);
		chk("txn", exp, {8'h0, OUT_VALID, OUT_PATH, OUT_CTX_FAULT,
			OUT_PATH === PATH_XLATE ? OUT_CB_INDEX : 4'h0, OUT_TRANSIENT, OUT_INSTR, OUT_PRIV,
			OUT_WALLOC, OUT_RALLOC, OUT_NS, OUT_MEMORY_ATTRIBUTE_VALUE, OUT_SHARE, OUT_BROADCAST, OUT_BARRIER,
			OUT_BAR_DOM});
	endtask
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			stop_test();
		end
	end
	////////////////////////
	initial begin
		repeat (16) @(posedge CLK);
		RST <= 1'b0;
		apb(1'b1, OFF_NS_COUNT, 32'h0000_0e00, 1'b0);
		apb(1'b0, OFF_NS_COUNT, 32'h0, 1'b0);
		chk("ns_count", 32'h0000_0e00, rd);
		apb(1'b1, OFF_NS_COUNT, 32'h0000_0300, 1'b1);
		apb(1'b0, OFF_NS_COUNT, 32'h0, 1'b1);
		chk("ns_count", 32'h0000_0e00, rd);
		wr_rd(12'h000, 32'hfffc_ffff, 32'hfff0_fb0f);
		wr_rd(12'h004, 32'hfffd_ffff, 32'h37f1_fb00);
		wr_rd(12'h008, 32'hfffe_ffff, 32'hf002_0000);
		wr_rd(12'h00c, 32'hffff_ffff, 32'h0003_0000);
		wr_rd(12'h050, 32'hffff_ffff, 32'h0);
		wr_rd(12'h03c, 32'h000c_0305, 32'h000c_0305);
		apb(1'b0, 12'h03c, 32'h0, 1'b1);
		chk("ns_view", 32'h0, rd);
		apb(1'b0, 12'h408, 32'h0, 1'b0);
		chk("slverr", 32'h1, {31'h0, er});
		apb(1'b1, 12'h000, 32'h3eec_a909, 1'b0);
		apb(1'b1, 12'h004, 32'h26b1_5200, 1'b0);
		stc_client_inst.send(1'b1, 8'h01, 16'heddd);
		stc_client_inst.send(1'b1, 8'h02, 16'h20cc);
		txn(1'b1, 8'h00, 16'h20cd, 32'h0089_caa5);
		txn(1'b1, 8'h01, 16'heddd, 32'h00a0_75de);
		txn(1'b1, 8'h0f, 16'h0020, 32'h0085_0400);
		for (int g = 2; g < 4; g++) begin
			txn(1'b1, 8'(g), 16'h20cc, 32'h00d0_20c0);
		end
		apb(1'b0, OFF_FAULT_COUNT, 32'h0, 1'b0);
		chk("fault_count", 32'h3, rd);
		// Barrier already above the group minimum must not be lowered
		txn(1'b1, 8'h01, 16'h000f, 32'h00a0_101f);
		txn(1'b0, 8'h01, 16'heddd, 32'h00e0_edd5);
		txn(1'b1, 8'h14, 16'heddd, 32'h00e0_edd5);
		stop_test();
	end
endmodule

/* verilog/stc_cfg_mem.sv */
// Two-read-port configuration word store with registered read data
module stc_cfg_mem #(
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [AW-1:0] ra_addr,
	output logic [31:0] ra_data,
	input wire logic [AW-1:0] rb_addr,
	output logic [31:0] rb_data
);

	// No reset: contents are undefined until software writes them
	logic [31:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		ra_data <= mem[ra_addr];
	end

	always_ff @(posedge clk) begin
		rb_data <= mem[rb_addr];
	end

endmodule

/* verilog/stream_context_attr.sv */
// Stream-to-context configuration registers and per-transaction attribute override path
//
// Notes on behaviour
// (RL1) Type field 17:16 selects translate, bypass, fault; 0b11 reserved.
// (RL2) Registers beyond the implemented count read zero, writes ignored.
// (RL3) Each register is 32-bit read/write with unknown reset content.
// (RL4) Transient field: keep, 10 non-transient, 11 transient; absent reads zero.
// (RL5) Translate format: 10 marks data, 11 marks instruction, else keep.
// (RL6) Translate format: 10 unprivileged, 11 privileged, else keep.
// (RL7) Write allocate: 10 allocate, 11 no allocate, else keep.
// (RL8) Read allocate: 10 allocate, 11 no allocate, else keep.
// (RL9) Security override only in secure groups: 10 secure, 11 non-secure.
// (RL10) Memory type bit set applies four-bit attribute field, else default.
// (RL11) Shareability: 01 outer, 10 inner, 11 non-shareable, 00 keep.
// (RL12) Context index width covers all banks, same everywhere, upper bits zero.
// (RL13) Bypass format passes untranslated but still applies attribute overrides.
// (RL14) Bypass with force bit turns maintenance operations into inner broadcasts.
// (RL15) Bypass raises barrier shareability to minimum domain; unsupported reads zero.
// (RL16) Secure translate entries point only at secure stage-1 banks.
// (RL17) Secure registers use secure banks; non-secure ones use unreserved banks.
// (RL18) Translate format: top two bits implementation use, bit 10 reserved.
// (RL19) Fault format raises invalid context fault and never forwards.
// (RL20) Overrides touch only transactions that matched the group.
//
// Added by the designer: the register addresses and the APB interface to the registers.
module stream_context_attr
	import stc_pkg::*;
#(
	parameter int NUM_GROUPS = 16,
	parameter int CB_W = 4,
	parameter bit TRANS_IMPL = 1'b1,
	parameter bit BSU_IMPL = 1'b1
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [2:0] PPROT,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic TXN_VALID,
	input wire logic TXN_MATCH,
	input wire logic [7:0] TXN_GROUP,
	input wire logic TXN_TRANSIENT,
	input wire logic TXN_INSTR,
	input wire logic TXN_PRIV,
	input wire logic TXN_WALLOC,
	input wire logic TXN_RALLOC,
	input wire logic TXN_NS,
	input wire logic [3:0] TXN_MEMORY_ATTRIBUTE_VALUE,
	input wire logic [1:0] TXN_SHARE,
	input wire logic TXN_MAINT,
	input wire logic TXN_BARRIER,
	input wire logic [1:0] TXN_BAR_DOM,
	output logic OUT_VALID,
	output logic [1:0] OUT_PATH,
	output logic [CB_W-1:0] OUT_CB_INDEX,
	output logic OUT_TRANSIENT,
	output logic OUT_INSTR,
	output logic OUT_PRIV,
	output logic OUT_WALLOC,
	output logic OUT_RALLOC,
	output logic OUT_NS,
	output logic [3:0] OUT_MEMORY_ATTRIBUTE_VALUE,
	output logic [1:0] OUT_SHARE,
	output logic OUT_BROADCAST,
	output logic OUT_BARRIER,
	output logic [1:0] OUT_BAR_DOM,
	output logic OUT_CTX_FAULT
);

	localparam int AW = (NUM_GROUPS > 1) ? $clog2(NUM_GROUPS) : 1;
	localparam logic [31:0] MASK_CB = 32'((64'd1 << CB_W) - 64'd1);
	localparam logic [8:0] GROUPS_N = 9'(NUM_GROUPS);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Keep only bits that hold storage for the format and group security
	function automatic logic [31:0] legal_bits(input logic [31:0] d, input logic sec);
		logic [31:0] m;
		m = '0;
		case (cfg_type_t'(d[TYPE_LSB +: 2])) // RL1
			CFG_XLATE: begin
				m = MASK_XLATE | MASK_CB; // RL12 RL18
			end
			CFG_BYPASS: begin
				m = MASK_BYPASS; // RL13
				if (BSU_IMPL) begin
					m = m | MASK_BSU; // RL15
				end
			end
			CFG_FAULT: begin
				m = MASK_FAULT;
			end
			default: begin
				m = MASK_RSVD;
			end
		endcase
		if (TRANS_IMPL && (d[TYPE_LSB +: 2] != CFG_FAULT) && (d[TYPE_LSB +: 2] != CFG_RSVD)) begin
			m = m | MASK_TRANS; // RL4
		end
		if (sec && (d[TYPE_LSB +: 2] != CFG_FAULT) && (d[TYPE_LSB +: 2] != CFG_RSVD)) begin
			m = m | MASK_SEC; // RL9
		end
		return d & m;
	endfunction

	// Two-bit force field: 10 forces val_a, 11 its inverse, others keep
	function automatic logic ovr(input logic dflt, input logic [1:0] f, input logic val_a);
		logic r;
		r = dflt;
		if (f == OVR_FORCE_A) begin
			r = val_a;
		end else if (f == OVR_FORCE_B) begin
			r = ~val_a;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// APB decode

	logic [7:0] ns_count_r;
	logic [15:0] fault_count_r;
	logic wait_done_r;
	logic [31:0] prdata_r;
	logic [31:0] mem_a_data;
	logic [31:0] mem_b_data;
	logic [7:0] bus_idx;
	logic bus_is_cfg;
	logic bus_impl;
	logic bus_sec_grp;
	logic bus_ns_acc;
	logic bus_cfg_ok;
	logic bus_mapped;
	logic bus_done;
	logic cfg_wr;

	assign bus_idx = PADDR[9:2];
	assign bus_is_cfg = (PADDR >= OFF_CFG_BASE) && (PADDR <= OFF_CFG_LAST);
	assign bus_impl = {1'b0, bus_idx} < GROUPS_N;
	assign bus_sec_grp = bus_idx >= ns_count_r;
	assign bus_ns_acc = PPROT[1];
	// Non-secure view of a secure group is empty, as if unimplemented
	assign bus_cfg_ok = bus_is_cfg && bus_impl && !(bus_ns_acc && bus_sec_grp); // RL2
	assign bus_mapped = (PADDR[1:0] == 2'b00)
		&& (bus_is_cfg || (PADDR == OFF_NS_COUNT) || (PADDR == OFF_FAULT_COUNT));
	assign bus_done = PSEL && PENABLE && wait_done_r;
	assign cfg_wr = bus_done && PWRITE && bus_mapped && bus_cfg_ok;

	// One wait state: the store's read data is registered
	assign PREADY = PSEL && PENABLE && wait_done_r;
	assign PSLVERR = PREADY && !bus_mapped;
	assign PRDATA = prdata_r;

	always_ff @(posedge CLK) begin
		if (RST) begin
			wait_done_r <= 1'b0;
		end else begin
			wait_done_r <= PSEL && PENABLE && !wait_done_r;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			prdata_r <= 32'h00000000;
		end else if (PSEL && PENABLE && !wait_done_r) begin
			prdata_r <= 32'h00000000;
			if (!PWRITE && bus_mapped) begin
				if (bus_cfg_ok) begin
					prdata_r <= legal_bits(mem_a_data, bus_sec_grp); // RL3
				end else if (PADDR == OFF_NS_COUNT) begin
					prdata_r <= {16'h0000, ns_count_r, 8'h00};
				end else if (PADDR == OFF_FAULT_COUNT) begin
					prdata_r <= {16'h0000, fault_count_r};
				end
			end
		end
	end

	// Group split point: groups at or above it belong to secure software
	always_ff @(posedge CLK) begin
		if (RST) begin
			ns_count_r <= GROUPS_N[7:0];
		end else if (bus_done && PWRITE && (PADDR == OFF_NS_COUNT) && !bus_ns_acc) begin
			ns_count_r <= PWDATA[NSCOUNT_LSB +: 8];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration store

	stc_cfg_mem #(
		.DEPTH(NUM_GROUPS),
		.AW(AW)
	) u_cfg_mem (
		.clk(CLK),
		.wr_en(cfg_wr),
		.wr_addr(bus_idx[AW-1:0]),
		.wr_data(legal_bits(PWDATA, bus_sec_grp)),
		.ra_addr(bus_idx[AW-1:0]),
		.ra_data(mem_a_data),
		.rb_addr(TXN_GROUP[AW-1:0]),
		.rb_data(mem_b_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Transaction stage 1: capture while the store is read

	logic s1_valid_r;
	logic s1_match_r;
	logic [7:0] s1_group_r;
	logic [5:0] s1_flags_r;
	logic [3:0] s1_memory_attribute_value_r;
	logic [1:0] s1_share_r;
	logic s1_maint_r;
	logic s1_barrier_r;
	logic [1:0] s1_bar_dom_r;

	always_ff @(posedge CLK) begin
		if (RST) begin
			s1_valid_r <= 1'b0;
		end else begin
			s1_valid_r <= TXN_VALID;
		end
	end

	always_ff @(posedge CLK) begin
		s1_match_r <= TXN_MATCH && ({1'b0, TXN_GROUP} < GROUPS_N);
		s1_group_r <= TXN_GROUP;
		s1_flags_r <= {TXN_TRANSIENT, TXN_INSTR, TXN_PRIV, TXN_WALLOC, TXN_RALLOC, TXN_NS};
		s1_memory_attribute_value_r <= TXN_MEMORY_ATTRIBUTE_VALUE;
		s1_share_r <= TXN_SHARE;
		s1_maint_r <= TXN_MAINT;
		s1_barrier_r <= TXN_BARRIER;
		s1_bar_dom_r <= TXN_BAR_DOM;
	end

	////////////////////////////////////////////////////////////////////////////
	// Transaction stage 2: decode and override

	logic [31:0] cfg;
	logic s1_sec_grp;
	logic [1:0] path_nxt;
	logic [CB_W-1:0] cb_nxt;
	logic [5:0] flags_nxt;
	logic [3:0] memory_attribute_value_nxt;
	logic [1:0] share_nxt;
	logic bcast_nxt;
	logic [1:0] bar_dom_nxt;

	assign s1_sec_grp = s1_group_r >= ns_count_r;
	assign cfg = legal_bits(mem_b_data, s1_sec_grp);

	always_comb begin
		path_nxt = PATH_NONE;
		cb_nxt = '0;
		flags_nxt = s1_flags_r;
		memory_attribute_value_nxt = s1_memory_attribute_value_r;
		share_nxt = s1_share_r;
		bcast_nxt = 1'b0;
		bar_dom_nxt = s1_bar_dom_r;
		// Unmatched traffic leaves untouched
		if (s1_match_r) begin // RL20
			case (cfg_type_t'(cfg[TYPE_LSB +: 2])) // RL1
				CFG_XLATE, CFG_BYPASS: begin
					if (cfg[TYPE_LSB +: 2] == CFG_XLATE) begin
						path_nxt = PATH_XLATE;
						cb_nxt = cfg[CB_LSB +: CB_W]; // RL12
						flags_nxt[4] = ovr(s1_flags_r[4], cfg[FETCH_LSB +: 2], 1'b0); // RL5
						flags_nxt[3] = ovr(s1_flags_r[3], cfg[PRIV_LSB +: 2], 1'b0); // RL6
					end else begin
						path_nxt = PATH_BYPASS; // RL13
						bcast_nxt = s1_maint_r && cfg[FB_BIT]; // RL14
						if (s1_barrier_r && (cfg[BSU_LSB +: 2] > s1_bar_dom_r)) begin
							bar_dom_nxt = cfg[BSU_LSB +: 2]; // RL15
						end
					end
					flags_nxt[5] = ovr(s1_flags_r[5], cfg[TRANS_LSB +: 2], 1'b0); // RL4
					flags_nxt[2] = ovr(s1_flags_r[2], cfg[WALLOC_LSB +: 2], 1'b1); // RL7
					flags_nxt[1] = ovr(s1_flags_r[1], cfg[RALLOC_LSB +: 2], 1'b1); // RL8
					if (s1_sec_grp) begin
						flags_nxt[0] = ovr(s1_flags_r[0], cfg[SEC_LSB +: 2], 1'b0); // RL9
					end
					if (cfg[MTSEL_BIT]) begin
						memory_attribute_value_nxt = cfg[MEMORY_ATTRIBUTE_VALUE_LSB +: 4]; // RL10
					end
					case (cfg[SHARE_LSB +: 2]) // RL11
						SHAREABILITY_OVERRIDE_OUTER: share_nxt = SH_OUTER;
						SHAREABILITY_OVERRIDE_INNER: share_nxt = SH_INNER;
						SHAREABILITY_OVERRIDE_NON: share_nxt = SH_NON;
						default: share_nxt = s1_share_r;
					endcase
				end
				default: begin
					// Reserved type is handled as fault: safest for unknown setups
					path_nxt = PATH_FAULT; // RL19
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			OUT_VALID <= 1'b0;
			OUT_CTX_FAULT <= 1'b0;
		end else begin
			OUT_VALID <= s1_valid_r;
			OUT_CTX_FAULT <= s1_valid_r && (path_nxt == PATH_FAULT); // RL19
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			OUT_PATH <= PATH_NONE;
			OUT_CB_INDEX <= '0;
			{OUT_TRANSIENT, OUT_INSTR, OUT_PRIV, OUT_WALLOC, OUT_RALLOC, OUT_NS} <= 6'h00;
			OUT_MEMORY_ATTRIBUTE_VALUE <= 4'h0;
			OUT_SHARE <= 2'h0;
			OUT_BROADCAST <= 1'b0;
			OUT_BARRIER <= 1'b0;
			OUT_BAR_DOM <= 2'h0;
		end else begin
			OUT_PATH <= path_nxt;
			OUT_CB_INDEX <= cb_nxt;
			{OUT_TRANSIENT, OUT_INSTR, OUT_PRIV, OUT_WALLOC, OUT_RALLOC, OUT_NS} <= flags_nxt;
			OUT_MEMORY_ATTRIBUTE_VALUE <= memory_attribute_value_nxt;
			OUT_SHARE <= share_nxt;
			OUT_BROADCAST <= bcast_nxt;
			OUT_BARRIER <= s1_barrier_r && (path_nxt != PATH_FAULT);
			OUT_BAR_DOM <= bar_dom_nxt;
		end
	end

	// Saturating count of invalid context faults, visible to software
	always_ff @(posedge CLK) begin
		if (RST) begin
			fault_count_r <= FAULT_COUNT_RST;
		end else if (s1_valid_r && (path_nxt == PATH_FAULT) && (fault_count_r != 16'hffff)) begin
			fault_count_r <= fault_count_r + 16'h0001;
		end
	end

endmodule
